// >>> sdc_map.vh
`ifndef SDC_MAP_VH
`define SDC_MAP_VH
// ****************************************
// Register byte offsets
// ****************************************
`define SDC_OFF_GLOBAL     4'h0
`define SDC_OFF_CHIP3      4'h4
`define SDC_OFF_CTRL       4'h8
`define SDC_OFF_TIMING     4'hc
// ****************************************
// Control register fields
// ****************************************
`define SDC_TRP_LSB        16
`define SDC_ACTIVATE_TO_ACCESS_DELAY_LSB       20
`define SDC_TRC_LSB        12
`define SDC_INIT_BIT       24
`define SDC_REFRESH_ENABLE_BIT       25
`define SDC_CSZ_LSB        26
`define SDC_RSZ_LSB        28
`define SDC_BSZ_BIT        30
`define SDC_CTRL_MASK      32'h7fff_f000
// ****************************************
// Global control and chip space fields
// ****************************************
`define SDC_SECOND_CLOCK_OUT_ENABLE_BIT     3
`define SDC_FIRST_CLOCK_OUT_ENABLE_BIT     4
`define SDC_GLOBAL_MASK    32'h0000_0018
`define SDC_MEMORY_TYPE_LSB      4
`define SDC_MEMORY_TYPE_SDRAM32  3'h3
// ****************************************
// Reset values
// ****************************************
`define SDC_PERIOD_RST     12'h040
`define SDC_CTRL_RST       32'h0000_0000
`define SDC_GLOBAL_RST     32'h0000_0018
`define SDC_CHIP3_RST      32'hffff_ff03
// ****************************************
// Init sequence length in refresh commands
// ****************************************
`define SDC_INIT_REFRESHES 4'h8
`endif

// >>> sdc_config.v
`timescale 1ns/100ps
`include "sdc_map.vh"

module sdc_config
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    // AXI4-Lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Geometry and mode outputs
    output reg  [3:0]  column_bits,
    output reg  [3:0]  row_bits,
    output reg  [1:0]  bank_bits,
    output reg         space_is_sdram,
    // Command strobes and access gate
    output reg         refresh_req,
    output reg         precharge_req,
    output reg         mode_set_req,
    output reg         access_hold,
    // Clock outputs
    output reg         burst_sram_clock,
    output reg         half_rate_clock_out
);

    // ****************************************
    // Registers and state
    // ****************************************
    localparam ST_IDLE  = 2'd0;
    localparam ST_PRE   = 2'd1;
    localparam ST_REF   = 2'd2;
    localparam ST_MRS   = 2'd3;

    reg [31:0] sdram_control_r;
    reg [31:0] global_memory_control_r;
    reg [31:0] chip_space_control_r;
    reg [11:0] refresh_period_r;
    reg [11:0] refresh_count_r;
    reg [1:0]  state_r;
    reg [3:0]  wait_r;
    reg [3:0]  init_left_r;
    reg        ref_pend_r;
    reg        half_div_r;
    reg [3:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;
    reg        aw_have_r;
    reg        w_have_r;

    wire [3:0] row_cycle_delay          = sdram_control_r[`SDC_TRC_LSB +: 4];
    wire [3:0] precharge_delay          = sdram_control_r[`SDC_TRP_LSB +: 4];
    wire [3:0] activate_to_access_delay = sdram_control_r[`SDC_ACTIVATE_TO_ACCESS_DELAY_LSB +: 4];
    wire [1:0] column_size              = sdram_control_r[`SDC_CSZ_LSB +: 2];
    wire [1:0] row_size                 = sdram_control_r[`SDC_RSZ_LSB +: 2];
    wire       bank_size                = sdram_control_r[`SDC_BSZ_BIT];
    wire       refresh_enable           = sdram_control_r[`SDC_REFRESH_ENABLE_BIT];
    wire [2:0] memory_type              = chip_space_control_r[`SDC_MEMORY_TYPE_LSB +: 3];
    wire       first_clock_out_enable   = global_memory_control_r[`SDC_FIRST_CLOCK_OUT_ENABLE_BIT];
    wire       second_clock_out_enable  = global_memory_control_r[`SDC_SECOND_CLOCK_OUT_ENABLE_BIT];

    // Byte-lane merge
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
    endfunction

    wire [31:0] ctrl_merged   = merge(sdram_control_r, w_data_r, w_strb_r);
    wire [31:0] timing_merged = merge({20'h0, refresh_period_r}, w_data_r, w_strb_r);
    wire do_write   = aw_have_r && w_have_r && !s_axi_bvalid;
    wire init_write = do_write && (aw_addr_r == `SDC_OFF_CTRL) && w_strb_r[3]
                      && w_data_r[`SDC_INIT_BIT];
    wire cnt_zero   = (refresh_count_r == 12'h000);
    wire [11:0] count_nxt = refresh_count_r - 12'h001;

    // ****************************************
    // AXI4-Lite write path and registers
    // ****************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready           <= 1'b0;
            s_axi_wready            <= 1'b0;
            s_axi_bvalid            <= 1'b0;
            s_axi_bresp             <= 2'b00;
            aw_have_r               <= 1'b0;
            w_have_r                <= 1'b0;
            aw_addr_r               <= 4'h0;
            w_data_r                <= 32'h0000_0000;
            w_strb_r                <= 4'h0;
            sdram_control_r         <= `SDC_CTRL_RST;
            global_memory_control_r <= `SDC_GLOBAL_RST;
            chip_space_control_r    <= `SDC_CHIP3_RST;
            refresh_period_r        <= `SDC_PERIOD_RST;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_write)
            begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (aw_addr_r)
                    `SDC_OFF_GLOBAL:
                        global_memory_control_r <= merge(global_memory_control_r, w_data_r, w_strb_r)
                                                   & `SDC_GLOBAL_MASK;
                    `SDC_OFF_CHIP3:
                        chip_space_control_r <= merge(chip_space_control_r, w_data_r, w_strb_r);
                    `SDC_OFF_CTRL:
                        sdram_control_r <= ctrl_merged & `SDC_CTRL_MASK & ~(32'h1 << `SDC_INIT_BIT);
                    `SDC_OFF_TIMING:
                        refresh_period_r <= timing_merged[11:0];
                    default:
                        s_axi_bresp <= 2'b10;
                endcase
            end
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end
        else if (clk_en)
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr)
                    `SDC_OFF_GLOBAL: s_axi_rdata <= global_memory_control_r;
                    `SDC_OFF_CHIP3:  s_axi_rdata <= chip_space_control_r;
                    `SDC_OFF_CTRL:   s_axi_rdata <= sdram_control_r | {7'h0, (state_r != ST_IDLE), 24'h0};
                    `SDC_OFF_TIMING: s_axi_rdata <= {8'h00, refresh_count_r, refresh_period_r};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Refresh counter, init and delay sequencer
    // ****************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            refresh_count_r <= `SDC_PERIOD_RST;
            ref_pend_r      <= 1'b0;
            state_r         <= ST_IDLE;
            wait_r          <= 4'h0;
            init_left_r     <= 4'h0;
            refresh_req     <= 1'b0;
            precharge_req   <= 1'b0;
            mode_set_req    <= 1'b0;
            access_hold     <= 1'b0;
        end
        else if (clk_en)
        begin
            refresh_req   <= 1'b0;
            precharge_req <= 1'b0;
            mode_set_req  <= 1'b0;
            if (cnt_zero)
                refresh_count_r <= refresh_period_r;
            else
                refresh_count_r <= count_nxt;
            if (cnt_zero && refresh_enable)
                ref_pend_r <= 1'b1;
            access_hold <= (state_r != ST_IDLE) || ref_pend_r || init_write;
            case (state_r)
                ST_IDLE:
                begin
                    if (init_write)
                    begin
                        state_r       <= ST_PRE;
                        precharge_req <= 1'b1;
                        init_left_r   <= `SDC_INIT_REFRESHES;
                        wait_r        <= ctrl_merged[`SDC_TRP_LSB +: 4];
                    end
                    else if (ref_pend_r)
                    begin
                        ref_pend_r  <= cnt_zero && refresh_enable;
                        state_r     <= ST_REF;
                        refresh_req <= 1'b1;
                        wait_r      <= row_cycle_delay;
                    end
                end
                ST_PRE:
                begin
                    if (wait_r != 4'h0)
                        wait_r <= wait_r - 4'h1;
                    else
                    begin
                        state_r     <= ST_REF;
                        refresh_req <= 1'b1;
                        init_left_r <= init_left_r - 4'h1;
                        wait_r      <= row_cycle_delay;
                    end
                end
                ST_REF:
                begin
                    if (wait_r != 4'h0)
                        wait_r <= wait_r - 4'h1;
                    else if (init_left_r != 4'h0)
                    begin
                        refresh_req <= 1'b1;
                        init_left_r <= init_left_r - 4'h1;
                        wait_r      <= row_cycle_delay;
                        if (init_left_r == 4'h1)
                            state_r <= ST_MRS;
                    end
                    else
                        state_r <= ST_IDLE;
                end
                ST_MRS:
                begin
                    if (wait_r != 4'h0)
                        wait_r <= wait_r - 4'h1;
                    else
                    begin
                        mode_set_req <= 1'b1;
                        state_r      <= ST_IDLE;
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Geometry decode and clock outputs
    // ****************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            column_bits         <= 4'h8;
            row_bits            <= 4'hb;
            bank_bits           <= 2'h1;
            space_is_sdram      <= 1'b0;
            burst_sram_clock    <= 1'b0;
            half_rate_clock_out <= 1'b0;
            half_div_r          <= 1'b0;
        end
        else if (clk_en)
        begin
            column_bits    <= 4'h8 + {2'b00, column_size};
            row_bits       <= 4'hb + {2'b00, row_size};
            bank_bits      <= bank_size ? 2'h2 : 2'h1;
            space_is_sdram <= (memory_type == `SDC_MEMORY_TYPE_SDRAM32);
            half_div_r     <= ~half_div_r;
            burst_sram_clock    <= first_clock_out_enable ? ~burst_sram_clock : 1'b0;
            half_rate_clock_out <= second_clock_out_enable ? (half_div_r ? ~half_rate_clock_out
                                                                           : half_rate_clock_out)
                                                           : 1'b0;
        end
    end

endmodule // sdc_config

// >>> sdc_config_chk.sv
`timescale 1ns/100ps
module sdc_config_chk
(
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Bus answers
    input wire        bvalid,
    input wire        bready,
    input wire [1:0]  bresp,
    input wire        rvalid,
    input wire        rready,
    input wire [31:0] rdata,
    // Geometry, commands and clocks
    input wire [3:0]  column_bits,
    input wire [1:0]  bank_bits,
    input wire        refresh_req,
    input wire        precharge_req,
    input wire        access_hold,
    input wire        burst_sram_clock,
    input wire        half_rate_clock_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****************************************
    // Init sequence steps, geometry, clock and bus checks
    // ****************************************
    sequence s_pre_all;
        precharge_req;
    endsequence
    sequence s_first_ref;
        ##[1:17] refresh_req;
    endsequence
    init_order_a: assert property (s_pre_all |-> s_first_ref)
        else $error("no refresh after precharge");
    ref_hold_a: assert property (refresh_req |-> access_hold)
        else $error("refresh without hold");
    pre_hold_a: assert property (precharge_req |=> access_hold)
        else $error("precharge without hold");
    col_range_a: assert property (column_bits >= 4'h8 && column_bits <= 4'hb)
        else $error("column width out of range");
    col_stable_a: assert property ($changed(column_bits) |-> $past(bvalid))
        else $error("column width moved without a write");
    bank_range_a: assert property (bank_bits == 2'h1 || bank_bits == 2'h2)
        else $error("bank width out of range");
    burst_tgl_a: assert property (burst_sram_clock |=> !burst_sram_clock)
        else $error("burst clock stuck high");
    half_tgl_a: assert property ($rose(half_rate_clock_out) |=> half_rate_clock_out || $past(bvalid))
        else $error("half rate clock too short");
    bresp_code_a: assert property (bvalid |-> !bresp[0])
        else $error("bad write response code");
    b_stand_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    r_stand_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
endmodule // sdc_config_chk

bind sdc_config sdc_config_chk chk
(
    .aclk(aclk), .aresetn(aresetn), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
    .bresp(s_axi_bresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready), .rdata(s_axi_rdata),
    .column_bits(column_bits), .bank_bits(bank_bits), .refresh_req(refresh_req),
    .precharge_req(precharge_req), .access_hold(access_hold),
    .burst_sram_clock(burst_sram_clock), .half_rate_clock_out(half_rate_clock_out)
);

// >>> sdc_sdram_model.sv
`timescale 1ns/100ps
module sdc_sdram_model
(
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Commands
    input  wire       refresh_req,
    input  wire       precharge_req,
    input  wire       mode_set_req,
    // Memory state
    output reg  [7:0] ref_count,
    output reg        mem_ready
);
    // Refreshes since precharge-all; ready once mode is set
    always @(posedge aclk)
    begin
        if (!aresetn || precharge_req)
        begin
            ref_count <= 8'h00;
            mem_ready <= 1'b0;
        end
        else
        begin
            if (refresh_req) ref_count <= ref_count + 8'h01;
            if (mode_set_req) mem_ready <= 1'b1;
        end
    end
endmodule // sdc_sdram_model

// >>> sdc_config_tb.sv
`timescale 1ns/100ps
`include "sdc_map.vh"
`define SDC_CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module sdc_config_tb;
    logic        aclk = 0, aresetn = 0, clk_en = 1;
    logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hf;
    logic [31:0] wdata = 0, d;
    logic [1:0]  r;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire         awready, wready, bvalid, arready, rvalid, space_is_sdram, refresh_req;
    wire         precharge_req, mode_set_req, access_hold, burst_sram_clock, half_rate_clock_out;
    wire  [1:0]  bresp, rresp, bank_bits;
    wire  [31:0] rdata;
    wire  [3:0]  column_bits, row_bits;
    wire  [7:0]  ref_count;
    wire         mem_ready;
    int          failures = 0, cmp_count = 0;
    always #50 aclk = ~aclk;
    sdc_config dut
    (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .column_bits(column_bits), .row_bits(row_bits), .bank_bits(bank_bits),
        .space_is_sdram(space_is_sdram), .refresh_req(refresh_req), .precharge_req(precharge_req),
        .mode_set_req(mode_set_req), .access_hold(access_hold), .burst_sram_clock(burst_sram_clock),
        .half_rate_clock_out(half_rate_clock_out)
    );
    sdc_sdram_model mem
    (
        .aclk(aclk), .aresetn(aresetn), .refresh_req(refresh_req), .precharge_req(precharge_req),
        .mode_set_req(mode_set_req), .ref_count(ref_count), .mem_ready(mem_ready)
    );
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(`SDC_OFF_GLOBAL);
        `SDC_CHK("global", 32'h0000_0018, d)
        rd(`SDC_OFF_TIMING);
        `SDC_CHK("period", 12'h040, d[11:0])
        `SDC_CHK("col", 4'h8, column_bits)
        rd(4'h2);
        `SDC_CHK("rresp", 2'h2, r)
        `SDC_CHK("rdata", 32'h0, d)
        wr(4'h2, 32'hffff_ffff);
        `SDC_CHK("bresp", 2'h2, r)
    endtask
    task automatic t_geom;
        wr(`SDC_OFF_CTRL, 32'h5811_6000);
        @(posedge aclk);
        `SDC_CHK("col", 4'ha, column_bits)
        `SDC_CHK("row", 4'hc, row_bits)
        `SDC_CHK("bank", 2'h2, bank_bits)
        rd(`SDC_OFF_CTRL);
        `SDC_CHK("ctrl", 32'h5811_6000, d)
        wr(`SDC_OFF_CHIP3, 32'hffff_ff33);
        @(posedge aclk);
        `SDC_CHK("sdram", 1'b1, space_is_sdram)
        wr(`SDC_OFF_CHIP3, 32'hffff_ff23);
        @(posedge aclk);
        `SDC_CHK("async", 1'b0, space_is_sdram)
        wstrb <= 4'h1;
        wr(`SDC_OFF_CHIP3, 32'h0000_0033);
        wstrb <= 4'hf;
        rd(`SDC_OFF_CHIP3);
        `SDC_CHK("strobe", 32'hffff_ff33, d)
        `SDC_CHK("sdram lane", 1'b1, space_is_sdram)
    endtask
    task automatic t_clk;
        logic b0;
        int h = 0, g = 0;
        wr(`SDC_OFF_GLOBAL, 32'h0000_0010);
        repeat (2) @(posedge aclk);
        b0 = burst_sram_clock;
        repeat (4)
        begin
            @(posedge aclk);
            h += half_rate_clock_out;
            g += burst_sram_clock;
        end
        `SDC_CHK("burst", b0, burst_sram_clock)
        `SDC_CHK("burst toggles", 2, g)
        `SDC_CHK("half off", 0, h)
        wr(`SDC_OFF_GLOBAL, 32'h0000_0008);
        h = 0;
        repeat (4)
        begin
            @(posedge aclk);
            h += half_rate_clock_out;
        end
        `SDC_CHK("half on", 2, h)
        `SDC_CHK("burst off", 1'b0, burst_sram_clock)
        wr(`SDC_OFF_GLOBAL, 32'h0000_0018);
    endtask
    task automatic t_init;
        int n = 0, tp = 0, tl = 0, nr = 0;
        fork
            wr(`SDC_OFF_CTRL, 32'h5911_6000);
            while (n < 300)
            begin
                @(posedge aclk);
                n++;
                if (precharge_req) tp = n;
                if (refresh_req && nr == 0) `SDC_CHK("trp", 2, n - tp)
                if (refresh_req && nr > 0) `SDC_CHK("trc", 7, n - tl)
                if (refresh_req) `SDC_CHK("hold", 1'b1, access_hold)
                if (refresh_req) tl = n;
                if (refresh_req) nr++;
                if (mode_set_req) n = 300;
            end
        join
        @(posedge aclk);
        `SDC_CHK("refs", 8, nr)
        `SDC_CHK("mem refs", 8'h08, ref_count)
        `SDC_CHK("ready", 1'b1, mem_ready)
    endtask
    task automatic t_ref;
        int n = 0, t2 = 0, nr = 0;
        wr(`SDC_OFF_TIMING, 32'h00ff_f00f);
        rd(`SDC_OFF_TIMING);
        `SDC_CHK("period", 12'h00f, d[11:0])
        `SDC_CHK("counter ro", 1'b1, d[23:12] <= 12'h040)
        wr(`SDC_OFF_CTRL, 32'h5a11_6000);
        while (nr < 4 && n < 200)
        begin
            @(posedge aclk);
            n++;
            if (refresh_req && nr == 3) `SDC_CHK("spacing", 16, n - t2)
            if (refresh_req) t2 = n;
            if (refresh_req) nr++;
        end
        `SDC_CHK("periodic", 4, nr)
        wr(`SDC_OFF_CTRL, 32'h5811_6000);
        repeat (20) @(posedge aclk);
        nr = 0;
        repeat (40)
        begin
            @(posedge aclk);
            nr += refresh_req;
        end
        `SDC_CHK("no refresh", 0, nr)
    endtask
    task wrap_up;
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_geom;
        t_clk;
        t_init;
        t_ref;
        wrap_up;
    end
    initial
    begin
        #(100 * 5000);
        failures++;
        wrap_up;
    end
endmodule // sdc_config_tb
